// ---- include/fpsr_pkg.sv ----
// constants, types and helpers for the fp stack register and exception block
package fpsr_pkg;

  localparam int NUM_REGS  = 8;
  localparam int DATA_W    = 80;
  localparam int IDX_W     = 3;
  localparam int EXC_W     = 6;

  // status word fields
  localparam int ST_BUSY_COPY = 15;
  localparam int ST_C3        = 14;
  localparam int ST_TOP_LO    = 11;
  localparam int ST_C2        = 10;
  localparam int ST_C1        = 9;
  localparam int ST_C0        = 8;
  localparam int ST_ES        = 7;
  localparam int ST_SF        = 6;

  // mode control fields
  localparam int MC_RC_LO = 10;
  localparam int MC_PC_LO = 8;

  // exception bit positions, shared by flags and masks
  localparam int EX_P = 5;
  localparam int EX_U = 4;
  localparam int EX_O = 3;
  localparam int EX_Z = 2;
  localparam int EX_D = 1;
  localparam int EX_I = 0;
  localparam logic [5:0] EXC_ABORTING = 6'h07;

  // reset values and writable bits
  localparam logic [15:0] MODE_RST   = 16'h033f;
  localparam logic [15:0] MODE_WMASK = 16'h0f3f;
  localparam logic [15:0] TAG_RST    = 16'hffff;
  localparam logic [2:0]  TOP_RST    = 3'h0;

  localparam logic [2:0] ONE_IDX = 3'h1;
  localparam logic [79:0] QNAN_INDEF = 80'hffff_c000_0000_0000_0000;

  typedef enum logic [1:0] {
    TAG_VALID   = 2'h0,
    TAG_ZERO    = 2'h1,
    TAG_SPECIAL = 2'h2,
    TAG_EMPTY   = 2'h3
  } fpsr_tag_e;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'h0,
    RND_DOWN    = 2'h1,
    RND_UP      = 2'h2,
    RND_TRUNC   = 2'h3
  } fpsr_round_e;

  typedef enum logic [1:0] {
    PREC_24  = 2'h0,
    PREC_RSV = 2'h1,
    PREC_53  = 2'h2,
    PREC_64  = 2'h3
  } fpsr_prec_e;

  typedef enum logic [3:0] {
    NOP_OP,
    LOAD_PUSH_OP,
    STORE_OP,
    ARITH_OP,
    COMPARE_OP,
    FREE_REG_OP,
    POINTER_INC_OP,
    POINTER_DEC_OP,
    CLEAR_EXC_OP
  } fpsr_op_e;

  function automatic logic [1:0] fpsr_classify(input logic [79:0] v);
    logic [14:0] ex;
    ex = v[78:64];
    if (ex == 15'h0000 && v[63:0] == 64'h0)
      return TAG_ZERO;
    else if (ex == 15'h7fff || ex == 15'h0000 || !v[63])
      return TAG_SPECIAL;
    else
      return TAG_VALID;
  endfunction

endpackage

// ---- design/fpsr_stack_mem.sv ----
// eight-entry data register array with registered read ports
`timescale 1ns/1ps
`default_nettype none
module fpsr_stack_mem #(
  parameter int W  = 80,
  parameter int N  = 8,
  parameter int AW = 3
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_a_addr,
  input  wire logic [AW-1:0] rd_b_addr,
  output var  logic [W-1:0]  rd_a_data,
  output var  logic [W-1:0]  rd_b_data
);
  logic [W-1:0] mem_ff [N];
  logic [W-1:0] rd_a_ff;
  logic [W-1:0] rd_b_ff;
  logic [W-1:0] nxt_rd_a;
  logic [W-1:0] nxt_rd_b;

  // reads see the contents before a same-edge write
  always_comb begin
    nxt_rd_a = mem_ff[rd_a_addr];
    nxt_rd_b = mem_ff[rd_b_addr];
  end

  // data array is left unreset; tags say what is meaningful
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_a_ff <= '0;
      rd_b_ff <= '0;
    end else begin
      rd_a_ff <= nxt_rd_a;
      rd_b_ff <= nxt_rd_b;
    end
  end

  assign rd_a_data = rd_a_ff;
  assign rd_b_data = rd_b_ff;
endmodule
`default_nettype wire

// ---- design/fpsr_stack_regs.sv ----
// fp register stack manager: tags, status, mode control and exception trap
`timescale 1ns/1ps
`default_nettype none
// How it works
// - eight 80-bit data registers addressed as a circular stack from top_index
// - push decrements top_index modulo 8, then writes the new top register
// - memory operands arrive converted; arithmetic result lands in top of stack, or in the relative register when op_to_reg is set without op_mem
// - relative register is top_index plus displacement, using the old top_index
// - two-bit tag per register: valid, zero, special, empty
// - tags change only by hardware; software only reads the tag word
// - reading an empty register raises source-empty error
// - writing a non-empty register by push or store raises destination-full error
// - register errors raise invalid and set stack_fault_flag
// - stores read top of stack and may pop afterwards
// - pop empties the top register then increments top_index modulo 8
// - arithmetic and compare forms may pop once; compares may pop twice
// - free marks a register empty; pointer ops step top_index only
// - status word is readable at every cycle
// - status holds codes, top_index, flags, fault, summary and its copy
// - round_ctl codes: nearest, down, up, truncate
// - precision_ctl codes: 24, reserved, 53, 64 bit mantissa
// - six masks, invalid and register error share one; 1 masks
// - flags set on exception; masked underflow needs precision too
// - fault_out_n follows unmasked flags, including a late unmask
// - unmasked zero-divide, denormal, invalid abort without writing
// - inexact results raise the precision flag
// - condition bit one tells destination-full from source-empty
// - masked register error writes quiet NaN indefinite; unmasked leaves it
module fpsr_stack_regs
  import fpsr_pkg::*;
#(
  parameter int DW = fpsr_pkg::DATA_W
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               op_valid,
  input  wire fpsr_pkg::fpsr_op_e op_code,
  input  wire logic [2:0]         op_disp,
  input  wire logic               op_mem,
  input  wire logic               op_to_reg,
  input  wire logic [1:0]         op_pop,
  input  wire logic [DW-1:0]      op_data,
  input  wire logic [5:0]         op_exc,
  input  wire logic               op_cc_we,
  input  wire logic [3:0]         op_cc,
  input  wire logic               mode_we,
  input  wire logic [15:0]        mode_wdata,
  output var  logic [15:0]        fpu_status_word,
  output var  logic [15:0]        fpu_mode_control,
  output var  logic [15:0]        register_tag_word,
  output var  logic [1:0]         round_ctl,
  output var  logic [1:0]         precision_ctl,
  output var  logic [DW-1:0]      tos_data,
  output var  logic [DW-1:0]      src_data,
  output var  logic               fault_out_n
);
  import fpsr_pkg::*;

  logic [2:0]  top_ff, nxt_top;
  logic [15:0] tag_ff, nxt_tag;
  logic [5:0]  flags_ff, nxt_flags;
  logic        sf_ff, nxt_sf;
  logic [3:0]  cc_ff, nxt_cc;
  logic [15:0] mode_ff, nxt_mode;
  logic [15:0] status_ff, nxt_status;
  logic        fault_n_ff, nxt_fault_n;

  logic [2:0]  src_idx, push_idx, dst_idx, top_p1;
  logic        is_num, src_empty, dst_full, reg_err, abort, do_write, es;
  logic [5:0]  exc_raw, exc_set, masks;
  logic [1:0]  pops;
  logic [DW-1:0] wr_val;

  function automatic logic empty_at(input logic [15:0] t, input logic [2:0] i);
    return t[2*i +: 2] == TAG_EMPTY;
  endfunction

  always_comb begin
    src_idx   = top_ff + op_disp;
    push_idx  = top_ff - ONE_IDX;
    top_p1    = top_ff + ONE_IDX;
    masks     = mode_ff[5:0];
    is_num    = op_valid && (op_code inside {LOAD_PUSH_OP, STORE_OP, ARITH_OP, COMPARE_OP});
    src_empty = 1'b0;
    dst_full  = 1'b0;
    dst_idx   = top_ff;
    if (op_valid) begin
      unique case (op_code)
        LOAD_PUSH_OP: begin
          src_empty = !op_mem && empty_at(tag_ff, src_idx);
          dst_full  = !empty_at(tag_ff, push_idx);
          dst_idx   = push_idx;
        end
        STORE_OP: begin
          src_empty = empty_at(tag_ff, top_ff);
          dst_full  = !op_mem && op_disp != 3'h0 && !empty_at(tag_ff, src_idx);
          dst_idx   = src_idx;
        end
        ARITH_OP, COMPARE_OP: begin
          src_empty = empty_at(tag_ff, top_ff) || (!op_mem && empty_at(tag_ff, src_idx));
          dst_idx   = (op_to_reg && !op_mem) ? src_idx : top_ff;
        end
        default: begin
          dst_idx = top_ff;
        end
      endcase
    end
    reg_err = src_empty || dst_full;
    // register error shares the invalid trap and its mask
    exc_raw = is_num ? (op_exc | {5'h00, reg_err}) : 6'h00;
    exc_set = exc_raw;
    if (masks[EX_U] && !exc_raw[EX_P]) begin
      exc_set[EX_U] = 1'b0;
    end
    abort    = |(exc_raw & ~masks & EXC_ABORTING);
    do_write = is_num && !abort && (op_code == LOAD_PUSH_OP || op_code == ARITH_OP ||
               (op_code == STORE_OP && !op_mem && op_disp != 3'h0));
    wr_val   = reg_err ? QNAN_INDEF : op_data;
    pops     = (is_num && !abort && op_code != LOAD_PUSH_OP) ? op_pop : 2'h0;
  end

  // stack pointer and tags
  always_comb begin
    nxt_top = top_ff;
    nxt_tag = tag_ff;
    if (do_write) begin
      nxt_tag[2*dst_idx +: 2] = reg_err ? TAG_SPECIAL : fpsr_classify(op_data);
    end
    if (is_num && !abort && op_code == LOAD_PUSH_OP) begin
      nxt_top = push_idx;
    end
    if (pops != 2'h0) begin
      nxt_tag[2*top_ff +: 2] = TAG_EMPTY;
      nxt_top = top_p1;
    end
    if (pops[1]) begin
      nxt_tag[2*top_p1 +: 2] = TAG_EMPTY;
      nxt_top = top_ff + 3'h2;
    end
    if (op_valid) begin
      unique case (op_code)
        FREE_REG_OP:    nxt_tag[2*src_idx +: 2] = TAG_EMPTY;
        POINTER_INC_OP: nxt_top = top_p1;
        POINTER_DEC_OP: nxt_top = push_idx;
        default:        nxt_top = nxt_top;
      endcase
    end
  end

  // flags, condition codes, mode and the trap line
  always_comb begin
    // new events win over a clear in the same cycle
    if (op_valid && op_code == CLEAR_EXC_OP) begin
      nxt_flags = exc_set;
      nxt_sf    = reg_err;
    end else begin
      nxt_flags = flags_ff | exc_set;
      nxt_sf    = sf_ff | reg_err;
    end
    nxt_cc = cc_ff;
    if (reg_err) begin
      nxt_cc[1] = dst_full;
    end else if (op_valid && op_cc_we && !abort) begin
      nxt_cc = op_cc;
    end
    nxt_mode = mode_we ? (mode_wdata & MODE_WMASK) : mode_ff;
    // compared every cycle, so unmasking a set flag traps at once
    es = |(nxt_flags & ~nxt_mode[5:0]);
    nxt_fault_n = !es;
    nxt_status  = {es, nxt_cc[3], nxt_top, nxt_cc[2], nxt_cc[1], nxt_cc[0],
                   es, nxt_sf, nxt_flags};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      top_ff     <= TOP_RST;
      tag_ff     <= TAG_RST;
      flags_ff   <= '0;
      sf_ff      <= 1'b0;
      cc_ff      <= '0;
      mode_ff    <= MODE_RST;
      status_ff  <= '0;
      fault_n_ff <= 1'b1;
    end else begin
      top_ff     <= nxt_top;
      tag_ff     <= nxt_tag;
      flags_ff   <= nxt_flags;
      sf_ff      <= nxt_sf;
      cc_ff      <= nxt_cc;
      mode_ff    <= nxt_mode;
      status_ff  <= nxt_status;
      fault_n_ff <= nxt_fault_n;
    end
  end

  // operand reads lag the request by one edge
  fpsr_stack_mem #(
    .W  (DW),
    .N  (NUM_REGS),
    .AW (IDX_W)
  ) u_mem (
    .clock     (clock),
    .reset     (reset),
    .wr_en     (do_write),
    .wr_addr   (dst_idx),
    .wr_data   (wr_val),
    .rd_a_addr (top_ff),
    .rd_b_addr (src_idx),
    .rd_a_data (tos_data),
    .rd_b_data (src_data)
  );

  assign fpu_status_word   = status_ff;
  assign fpu_mode_control  = mode_ff;
  assign register_tag_word = tag_ff;
  assign round_ctl         = mode_ff[MC_RC_LO +: 2];
  assign precision_ctl     = mode_ff[MC_PC_LO +: 2];
  assign fault_out_n       = fault_n_ff;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  property p_push_dec;
    (is_num && op_code == LOAD_PUSH_OP && !abort) |=> top_ff == $past(top_ff) - 3'h1;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not step top down");

  property p_pop_one;
    (pops == 2'h1 && op_code == STORE_OP) |=> top_ff == $past(top_ff) + 3'h1 &&
      register_tag_word[2*$past(top_ff) +: 2] == TAG_EMPTY;
  endproperty
  a_pop_one: assert property (p_pop_one) else $error("pop did not empty top and step up");

  property p_src_empty;
    (src_empty && !dst_full) |=> flags_ff[EX_I] && sf_ff && !cc_ff[1];
  endproperty
  a_src_empty: assert property (p_src_empty) else $error("source empty not reported");

  property p_dst_full;
    dst_full |=> flags_ff[EX_I] && sf_ff && cc_ff[1] && fpu_status_word[ST_C1];
  endproperty
  a_dst_full: assert property (p_dst_full) else $error("destination full not reported");

  property p_fault_tracks;
    fault_out_n == !(|(flags_ff & ~mode_ff[5:0]));
  endproperty
  a_fault_tracks: assert property (p_fault_tracks) else $error("fault line disagrees with flags");

  property p_unmask_trap;
    (mode_we && flags_ff[EX_P] && !mode_wdata[EX_P] && !(op_valid && op_code == CLEAR_EXC_OP))
      |=> !fault_out_n && fpu_status_word[ST_ES];
  endproperty
  a_unmask_trap: assert property (p_unmask_trap) else $error("unmasking a set flag did not trap");

  property p_masked_uflow;
    (is_num && masks[EX_U] && op_exc[EX_U] && !op_exc[EX_P] && !flags_ff[EX_U]
      && op_code != CLEAR_EXC_OP) |=> !flags_ff[EX_U];
  endproperty
  a_masked_uflow: assert property (p_masked_uflow) else $error("masked underflow set without precision");

  property p_abort_hold;
    (is_num && abort) |=> $stable(top_ff) && $stable(tag_ff);
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("aborted op changed the stack");

  property p_free;
    (op_valid && op_code == FREE_REG_OP) |=> register_tag_word[2*$past(src_idx) +: 2] == TAG_EMPTY;
  endproperty
  a_free: assert property (p_free) else $error("free did not empty the register");

  // data read lags the write by one edge, so the value is checked a cycle after the tag
  property p_masked_qnan;
    (do_write && reg_err && op_code == LOAD_PUSH_OP) |=> register_tag_word[2*top_ff +: 2] == TAG_SPECIAL
      ##1 tos_data == QNAN_INDEF;
  endproperty
  a_masked_qnan: assert property (p_masked_qnan) else $error("masked error did not write indefinite");

  property p_pop_two;
    (pops == 2'h2) |=> top_ff == $past(top_ff) + 3'h2 &&
      register_tag_word[2*$past(top_p1) +: 2] == TAG_EMPTY;
  endproperty
  a_pop_two: assert property (p_pop_two) else $error("double pop did not empty two entries");

  property p_status_top;
    fpu_status_word[ST_TOP_LO +: 3] == top_ff && fpu_status_word[ST_BUSY_COPY] == fpu_status_word[ST_ES];
  endproperty
  a_status_top: assert property (p_status_top) else $error("status word fields out of step");

  property p_ptr_step;
    (op_valid && op_code == POINTER_INC_OP) |=> top_ff == $past(top_ff) + 3'h1 && $stable(tag_ff);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step moved tags or missed");

  property p_mode_wr;
    mode_we |=> fpu_mode_control == ($past(mode_wdata) & MODE_WMASK);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write not taken");

  c_push: cover property (is_num && op_code == LOAD_PUSH_OP && !abort);
  c_pop_two: cover property (pops == 2'h2);
  c_reg_err: cover property (reg_err ##1 !fault_out_n);
  c_late_unmask: cover property (mode_we && flags_ff[EX_I] && !mode_wdata[EX_I]);
endmodule
`default_nettype wire

// ---- tb/fpsr_host_model.sv ----
// host model issuing stack operations and mode writes
`timescale 1ns/1ps
`default_nettype none
module fpsr_host_model (
  input  wire logic               clock,
  output var  fpsr_pkg::fpsr_op_e op_code,
  output var  logic               op_valid,
  output var  logic [2:0]         op_disp,
  output var  logic               op_mem,
  output var  logic               op_to_reg,
  output var  logic [1:0]         op_pop,
  output var  logic [79:0]        op_data,
  output var  logic [5:0]         op_exc,
  output var  logic               op_cc_we,
  output var  logic [3:0]         op_cc,
  output var  logic               mode_we,
  output var  logic [15:0]        mode_wdata
);
  import fpsr_pkg::*;
  initial begin
    {op_valid, op_disp, op_mem, op_to_reg, op_pop, op_data} = '0;
    {op_exc, op_cc_we, op_cc, mode_we, mode_wdata} = '0;
    op_code = NOP_OP;
  end
  // fields change only just after an edge, one op per edge
  task automatic issue(input fpsr_op_e c, input logic [2:0] d, input logic m, t, input logic [1:0] p,
                       input logic [79:0] v, input logic [5:0] x, input logic w, input logic [3:0] cc);
    @(posedge clock);
    op_code <= c;
    {op_valid, mode_we, op_disp, op_mem, op_to_reg, op_pop} <= {2'b10, d, m, t, p};
    {op_data, op_exc, op_cc_we, op_cc} <= {v, x, w, cc};
  endtask
  task automatic mode_wr(input logic [15:0] w);
    @(posedge clock);
    {op_valid, mode_we, mode_wdata} <= {2'b01, w};
  endtask
  // released data bus shows a changed pattern, not the old value
  task automatic idle();
    @(posedge clock);
    {op_valid, mode_we} <= 2'b00;
    op_data <= ~op_data;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the fp register stack block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpsr_pkg::*;
  typedef struct packed {
    logic [15:0] st;
    logic [15:0] tg;
    logic [15:0] md;
    logic        cs;
    logic [79:0] src;
    logic [79:0] tos;
  } fpsr_exp_s;
  logic        clock;
  logic        reset;
  fpsr_op_e    op_code;
  logic        op_valid;
  logic [2:0]  op_disp;
  logic        op_mem;
  logic        op_to_reg;
  logic [1:0]  op_pop;
  logic [79:0] op_data;
  logic [5:0]  op_exc;
  logic        op_cc_we;
  logic [3:0]  op_cc;
  logic        mode_we;
  logic [15:0] mode_wdata;
  logic [15:0] fpu_status_word;
  logic [15:0] fpu_mode_control;
  logic [15:0] register_tag_word;
  logic [1:0]  round_ctl;
  logic [1:0]  precision_ctl;
  logic [79:0] tos_data;
  logic [79:0] src_data;
  logic        fault_out_n;
  logic [2:0]  e_top;
  logic [15:0] e_tag;
  logic [5:0]  e_flg;
  logic        e_sf;
  logic [3:0]  e_cc;
  logic [15:0] e_md;
  logic [79:0] phys [8];
  fpsr_exp_s   expq [$];
  fpsr_exp_s   cur;
  logic        pend;
  logic [79:0] v;
  int          errors;
  int          check_count;
  int          seed;
  int          cycles;
  int          i;

  fpsr_stack_regs u_fpsr_stack_regs (.clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .op_disp(op_disp), .op_mem(op_mem), .op_to_reg(op_to_reg), .op_pop(op_pop), .op_data(op_data),
    .op_exc(op_exc), .op_cc_we(op_cc_we), .op_cc(op_cc), .mode_we(mode_we), .mode_wdata(mode_wdata),
    .fpu_status_word(fpu_status_word), .fpu_mode_control(fpu_mode_control),
    .register_tag_word(register_tag_word), .round_ctl(round_ctl), .precision_ctl(precision_ctl),
    .tos_data(tos_data), .src_data(src_data), .fault_out_n(fault_out_n));
  fpsr_host_model u_fpsr_host_model (.clock(clock), .op_code(op_code), .op_valid(op_valid),
    .op_disp(op_disp), .op_mem(op_mem), .op_to_reg(op_to_reg), .op_pop(op_pop), .op_data(op_data),
    .op_exc(op_exc), .op_cc_we(op_cc_we), .op_cc(op_cc), .mode_we(mode_we), .mode_wdata(mode_wdata));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [15:0] exp_st();
    logic es;
    es = |(e_flg & ~e_md[5:0]);
    return {es, e_cc[3], e_top, e_cc[2:0], es, e_sf, e_flg};
  endfunction
  task automatic cmp(input string nm, input logic [79:0] ex, got);
    check_count++;
    if (got !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic settag(input logic [2:0] r, input logic [1:0] t);
    e_tag[2*r +: 2] = t;
  endtask
  task automatic op(input fpsr_op_e c, input logic [2:0] d, input logic m, t, input logic [1:0] p,
                    input logic [79:0] val, input logic [5:0] x, input logic w, input logic [3:0] cc);
    u_fpsr_host_model.issue(c, d, m, t, p, val, x, w, cc);
    expq.push_back({exp_st(), e_tag, e_md, 1'b0, 80'h0, 80'h0});
  endtask
  task automatic nop_chk(input logic [2:0] d);
    u_fpsr_host_model.issue(NOP_OP, d, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    expq.push_back({exp_st(), e_tag, e_md, 1'b1, phys[3'(e_top + d)], phys[e_top]});
  endtask
  task automatic mode(input logic [15:0] w);
    e_md = w & MODE_WMASK;
    u_fpsr_host_model.mode_wr(w);
    expq.push_back({exp_st(), e_tag, e_md, 1'b0, 80'h0, 80'h0});
  endtask
  task automatic done(input string nm);
    u_fpsr_host_model.idle();
    repeat (2) @(posedge clock);
    $display("test %s finished", nm);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // results show one cycle after each op edge
  always @(posedge clock) pend <= op_valid | mode_we;
  always @(negedge clock) begin
    if (pend) begin
      cur = expq.pop_front();
      cmp("status", cur.st, fpu_status_word);
      cmp("tags", cur.tg, register_tag_word);
      cmp("mode", cur.md, fpu_mode_control);
      cmp("round", cur.md[11:10], round_ctl);
      cmp("precision", cur.md[9:8], precision_ctl);
      cmp("fault", !cur.st[7], fault_out_n);
      if (cur.cs) begin
        cmp("operand", cur.src, src_data);
        cmp("top data", cur.tos, tos_data);
      end
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      summarize();
    end
  end

  initial begin
    {errors, check_count, cycles, pend} = '0;
    seed = 32'h9837;
    reset = 1'b1;
    {e_top, e_tag, e_flg, e_sf, e_cc, e_md} = {TOP_RST, TAG_RST, 6'h0, 1'b0, 4'h0, MODE_RST};
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    cmp("reset status", exp_st(), fpu_status_word);
    cmp("reset tags", TAG_RST, register_tag_word);
    cmp("reset mode", MODE_RST, fpu_mode_control);
    for (i = 0; i < 8; i++) begin
      v = {1'b0, 15'h3fff, 1'b1, 32'($random(seed)), 31'($random(seed))};
      if (i == 0) v = 80'h0;
      if (i == 1) v = 80'h7fff_8000_0000_0000_0000;
      e_top--;
      phys[e_top] = v;
      settag(e_top, (i == 0) ? TAG_ZERO : (i == 1) ? TAG_SPECIAL : TAG_VALID);
      op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h0, 1'b0, 4'h0);
    end
    done("push");
    e_top++;
    op(POINTER_INC_OP, 3'h0, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    for (i = 0; i < 8; i++)
      nop_chk(3'(i));
    e_top--;
    op(POINTER_DEC_OP, 3'h0, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    done("relative");
    {e_top, e_flg, e_sf, e_cc} = {3'h7, 6'h01, 1'b1, 4'h2};
    settag(3'h7, TAG_SPECIAL);
    phys[7] = QNAN_INDEF;
    op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h0, 1'b0, 4'h0);
    nop_chk(3'h0);
    mode(16'h033e);
    {e_flg, e_sf} = 7'h0;
    op(CLEAR_EXC_OP, 3'h0, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    done("overflow");
    settag(3'h7, TAG_EMPTY);
    e_top = 3'h0;
    op(STORE_OP, 3'h0, 1'b1, 1'b0, 2'h1, 80'h0, 6'h0, 1'b0, 4'h0);
    settag(3'h0, TAG_EMPTY);
    settag(3'h1, TAG_EMPTY);
    {e_top, e_cc} = {3'h2, 4'h7};
    op(COMPARE_OP, 3'h1, 1'b0, 1'b0, 2'h2, 80'h0, 6'h0, 1'b1, 4'h7);
    v = {1'b1, 15'h4001, 1'b1, 32'($random(seed)), 31'($random(seed))};
    phys[3] = v;
    settag(3'h2, TAG_EMPTY);
    e_top = 3'h3;
    op(ARITH_OP, 3'h1, 1'b0, 1'b1, 2'h1, v, 6'h0, 1'b0, 4'h0);
    nop_chk(3'h0);
    done("pops");
    while (e_top != 3'h7) begin
      settag(e_top, TAG_EMPTY);
      e_top++;
      op(STORE_OP, 3'h0, 1'b1, 1'b0, 2'h1, 80'h0, 6'h0, 1'b0, 4'h0);
    end
    {e_flg, e_sf, e_cc} = {6'h01, 1'b1, 4'h5};
    op(STORE_OP, 3'h0, 1'b1, 1'b0, 2'h1, 80'h0, 6'h0, 1'b0, 4'h0);
    done("underflow of stack");
    {e_flg, e_sf} = 7'h0;
    op(CLEAR_EXC_OP, 3'h0, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    e_top = 3'h6;
    settag(3'h6, TAG_VALID);
    op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h10, 1'b0, 4'h0);
    {e_top, e_flg} = {3'h5, 6'h30};
    settag(3'h5, TAG_VALID);
    op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h30, 1'b0, 4'h0);
    mode(16'h033a);
    e_flg = 6'h34;
    op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h04, 1'b0, 4'h0);
    e_flg = 6'h0;
    op(CLEAR_EXC_OP, 3'h0, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    mode(16'h031f);
    {e_top, e_flg} = {3'h4, 6'h20};
    settag(3'h4, TAG_VALID);
    op(LOAD_PUSH_OP, 3'h0, 1'b1, 1'b0, 2'h0, v, 6'h20, 1'b0, 4'h0);
    settag(3'h5, TAG_EMPTY);
    op(FREE_REG_OP, 3'h1, 1'b0, 1'b0, 2'h0, 80'h0, 6'h0, 1'b0, 4'h0);
    {phys[4], phys[5]} = {v, v};
    settag(3'h5, TAG_VALID);
    op(STORE_OP, 3'h1, 1'b0, 1'b0, 2'h0, v, 6'h0, 1'b0, 4'h0);
    {e_flg, e_sf, e_cc} = {6'h21, 1'b1, 4'h7};
    phys[6] = QNAN_INDEF;
    settag(3'h6, TAG_SPECIAL);
    op(STORE_OP, 3'h2, 1'b0, 1'b0, 2'h0, v, 6'h0, 1'b0, 4'h0);
    nop_chk(3'h1);
    nop_chk(3'h2);
    done("exceptions");
    for (i = 0; i < 4; i++)
      mode({4'($random(seed)), 2'(i), 2'(3 - i), 2'($random(seed)), 6'($random(seed))});
    done("mode fields");
    summarize();
  end
endmodule
`default_nettype wire
